// [hdl/vof_formatter.sv]
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module vof_formatter
	import vof_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// decoder side, from another clock domain
	input wire logic i_pix_clk,
	input wire pair_t i_pair,
	input wire sync_t i_sync,
	input wire logic [9:0] i_pair_count,
	// host pins
	output logic [7:0] o_data,
	output logic o_line_valid_strobe,
	output logic o_frame_valid_strobe,
	output logic o_pixel_valid_out,
	output logic o_pixel_clock_out,
	output logic o_horizontal_sync_out,
	output logic o_vertical_sync_out
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] out_ctrl_q;
	logic [7:0] out_pol_q;
	logic [7:0] out_mode_q;
	logic range_limit_select;
	logic [2:0] output_size_select;
	intf_t intf;
	logic embed_mode;
	logic strobe_en;
	logic size_ok;

	assign range_limit_select = out_ctrl_q[BIT_RANGE_LIMIT];
	assign output_size_select = out_ctrl_q[2:0];
	assign intf = intf_t'(out_ctrl_q[BIT_INTF_LO+1:BIT_INTF_LO]);
	assign embed_mode = out_mode_q[BIT_MODE_EMBED];
	assign strobe_en = out_mode_q[BIT_MODE_STROBE_EN];

	// sizes allowed for each style; an illegal pair outputs black
	function automatic logic size_legal(input intf_t f, input logic [2:0] s);
		case (f)
			INTF_CAMERA: size_legal = (s == SIZE_QVGA) || (s == SIZE_CIF) ||
				(s == SIZE_QCIF) || (s == SIZE_QVGA_ROT) || (s == SIZE_CIF_ROT);
			INTF_SYNC: size_legal = (s == SIZE_QVGA) || (s == SIZE_VGA) ||
				(s == SIZE_CIF) || (s == SIZE_QCIF);
			INTF_656: size_legal = (s == SIZE_601);
			default: size_legal = 1'b0;
		endcase
	endfunction

	assign size_ok = size_legal(intf, output_size_select);

	// register writes
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			out_ctrl_q <= RESET_OUT_CTRL;
			out_pol_q <= RESET_OUT_POL;
			out_mode_q <= RESET_OUT_MODE;
		end
		else if (i_wr)
		begin
			if (i_addr == ADDR_OUT_CTRL)
				out_ctrl_q <= i_wdata;
			if (i_addr == ADDR_OUT_POL)
				out_pol_q <= {4'h0, i_wdata[3:0]};
			if (i_addr == ADDR_OUT_MODE)
				out_mode_q <= {6'h00, i_wdata[1:0]};
		end
	end

	// ------------------------------------------------------------
	// input crossing
	// ------------------------------------------------------------
	// the pixel clock is sampled, not used; data must hold for a pixel period
	logic pclk_s;
	logic pclk_d_q;
	logic pclk_rise;
	pair_t pair_s;
	sync_t sync_s;
	logic [9:0] count_s;

	vof_sync2 #(.WIDTH(1)) u_sync_clk (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_async(i_pix_clk),
		.o_sync(pclk_s)
	);
	vof_sync2 #(.WIDTH(32 + 5 + 10)) u_sync_data (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_async({i_pair, i_sync, i_pair_count}),
		.o_sync({pair_s, sync_s, count_s})
	);

	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
			pclk_d_q <= 1'b0;
		else
			pclk_d_q <= pclk_s;
	end
	assign pclk_rise = pclk_s & ~pclk_d_q;

	// status readback: lock, no-signal, size legality
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			case (i_addr)
				ADDR_OUT_CTRL: o_rdata <= out_ctrl_q;
				ADDR_OUT_POL: o_rdata <= out_pol_q;
				ADDR_OUT_MODE: o_rdata <= out_mode_q;
				ADDR_STATUS: o_rdata <= {5'h00, size_ok, sync_s.no_signal, sync_s.locked};
				default: o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// clipping
	// ------------------------------------------------------------
	pair_t src_pair;
	pair_t clip_pair;
	logic out_enable;
	logic send_black;

	// timed output only while locked or declared signal-free
	assign out_enable = sync_s.locked | sync_s.no_signal;
	assign send_black = sync_s.no_signal | ~size_ok;

	// black levels already lie inside both ranges, so they pass unchanged
	assign src_pair = send_black ? '{BLACK_CHROMA, BLACK_LUMA, BLACK_CHROMA, BLACK_LUMA} :
		i_pair_int(pair_s);

	function automatic pair_t i_pair_int(input pair_t p);
		pair_t r;
		r = p;
		if (r.cb == 8'h00) r.cb = CODE_MIN_FULL;
		if (r.y0 == 8'h00) r.y0 = CODE_MIN_FULL;
		if (r.cr == 8'h00) r.cr = CODE_MIN_FULL;
		if (r.y1 == 8'h00) r.y1 = CODE_MIN_FULL;
		if (r.cb == 8'hff) r.cb = CODE_MAX_FULL;
		if (r.y0 == 8'hff) r.y0 = CODE_MAX_FULL;
		if (r.cr == 8'hff) r.cr = CODE_MAX_FULL;
		if (r.y1 == 8'hff) r.y1 = CODE_MAX_FULL;
		i_pair_int = r;
	endfunction

	vof_clip u_clip (
		.i_range_limit(range_limit_select),
		.i_pair(src_pair),
		.o_pair(clip_pair)
	);

	// ------------------------------------------------------------
	// byte sequencer
	// ------------------------------------------------------------
	// with codes on, each line: four preamble/code bytes, then active pairs, then end code; with codes off, active pairs only
	typedef enum {ST_IDLE, ST_SAV, ST_ACTIVE, ST_EAV, ST_GAP} state_t;
	state_t state_q;
	logic [1:0] byte_q;
	logic [9:0] pairs_left_q;
	logic blank_line_q;
	pair_t hold_q;
	logic [7:0] data_q;
	logic line_valid_q;
	logic frame_valid_q;
	logic pixel_valid_q;
	logic hsync_q;
	logic vsync_q;
	logic codes_on;
	logic [7:0] sav_code;
	logic [7:0] eav_code;

	assign codes_on = (intf == INTF_656) || ((intf == INTF_CAMERA) && embed_mode);
	assign sav_code = blank_line_q ? CODE_SAV_VBLANK : CODE_SAV_ACTIVE;
	assign eav_code = blank_line_q ? CODE_EAV_VBLANK : CODE_EAV_ACTIVE;

	// code words go out as ff 00 00 code
	function automatic logic [7:0] code_byte(input logic [1:0] idx, input logic [7:0] c);
		case (idx)
			2'h0: code_byte = CODE_PREAMBLE_FF;
			2'h3: code_byte = c;
			default: code_byte = CODE_PREAMBLE_00;
		endcase
	endfunction

	// state advances once per sampled pixel clock edge
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			state_q <= ST_IDLE;
			byte_q <= 2'h0;
			pairs_left_q <= 10'h000;
			blank_line_q <= 1'b1;
			hold_q <= '0;
		end
		else if (!out_enable)
		begin
			state_q <= ST_IDLE;
			byte_q <= 2'h0;
		end
		else if (pclk_rise)
		begin
			// a new line start restarts the line, absorbing drift
			if (sync_s.line_start)
			begin
				state_q <= codes_on ? ST_SAV : ST_ACTIVE;
				byte_q <= 2'h0;
				blank_line_q <= ~sync_s.active_line;
				pairs_left_q <= count_s;
				hold_q <= clip_pair;
			end
			else
			begin
				byte_q <= byte_q + 2'h1;
				case (state_q)
					ST_SAV:
						if (byte_q == 2'h3)
							state_q <= ST_ACTIVE;
					ST_ACTIVE:
					begin
						if (byte_q == 2'h3)
						begin
							hold_q <= clip_pair;
							pairs_left_q <= pairs_left_q - 10'h001;
							if (pairs_left_q <= 10'h001)
								state_q <= codes_on ? ST_EAV : ST_GAP;
						end
					end
					ST_EAV:
						if (byte_q == 2'h3)
							state_q <= ST_GAP;
					ST_GAP: state_q <= ST_GAP;
					ST_IDLE: state_q <= ST_IDLE;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// byte lane choice in cb, y, cr, y order
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
			data_q <= 8'h00;
		else if (pclk_rise)
		begin
			case (state_q)
				ST_SAV: data_q <= code_byte(byte_q, sav_code);
				ST_EAV: data_q <= code_byte(byte_q, eav_code);
				ST_ACTIVE:
					case (byte_q)
						2'h0: data_q <= hold_q.cb;
						2'h1: data_q <= hold_q.y0;
						2'h2: data_q <= hold_q.cr;
						default: data_q <= hold_q.y1;
					endcase
				default: data_q <= BLACK_LUMA;
			endcase
		end
	end

	// strobes, before polarity
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			line_valid_q <= 1'b0;
			frame_valid_q <= 1'b0;
			pixel_valid_q <= 1'b0;
			hsync_q <= 1'b0;
			vsync_q <= 1'b0;
		end
		else if (pclk_rise)
		begin
			// line valid falls at line end; frame valid falls while frame end is marked
			line_valid_q <= (intf == INTF_CAMERA) && (!embed_mode || strobe_en) &&
				(state_q == ST_ACTIVE) && !blank_line_q;
			frame_valid_q <= (intf == INTF_CAMERA) && (!embed_mode || strobe_en) &&
				!sync_s.frame_end;
			pixel_valid_q <= (intf == INTF_SYNC) && (state_q == ST_ACTIVE) &&
				!blank_line_q;
			hsync_q <= (intf == INTF_SYNC) && sync_s.line_start;
			vsync_q <= (intf == INTF_SYNC) && sync_s.frame_end;
		end
	end

	// ------------------------------------------------------------
	// output pins
	// ------------------------------------------------------------
	// polarity applied in the last flop so every pin is registered
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_data <= 8'h00;
			o_line_valid_strobe <= 1'b0;
			o_frame_valid_strobe <= 1'b0;
			o_pixel_valid_out <= 1'b0;
			o_pixel_clock_out <= 1'b0;
			o_horizontal_sync_out <= 1'b0;
			o_vertical_sync_out <= 1'b0;
		end
		else
		begin
			o_data <= data_q;
			o_line_valid_strobe <= line_valid_q ^ out_pol_q[BIT_POL_LINE];
			o_frame_valid_strobe <= frame_valid_q ^ out_pol_q[BIT_POL_FRAME];
			o_pixel_valid_out <= pixel_valid_q ^ out_pol_q[BIT_POL_VALID];
			o_pixel_clock_out <= pclk_d_q ^ out_pol_q[BIT_POL_CLK];
			o_horizontal_sync_out <= hsync_q;
			o_vertical_sync_out <= vsync_q;
		end
	end

endmodule
`default_nettype wire

// [hdl/vof_pkg.sv]
package vof_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_OUT_CTRL = 8'h01;
	localparam logic [7:0] ADDR_OUT_POL = 8'h02;
	localparam logic [7:0] ADDR_OUT_MODE = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] RESET_OUT_CTRL = 8'h00;
	localparam logic [7:0] RESET_OUT_POL = 8'h00;
	localparam logic [7:0] RESET_OUT_MODE = 8'h00;
	localparam int BIT_RANGE_LIMIT = 3;
	localparam int BIT_INTF_LO = 4;
	localparam int BIT_POL_FRAME = 0;
	localparam int BIT_POL_LINE = 1;
	localparam int BIT_POL_VALID = 2;
	localparam int BIT_POL_CLK = 3;
	localparam int BIT_MODE_EMBED = 0;
	localparam int BIT_MODE_STROBE_EN = 1;

	// ------------------------------------------------------------
	// code limits
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_MIN_FULL = 8'h01;
	localparam logic [7:0] CODE_MAX_FULL = 8'hfe;
	localparam logic [7:0] CODE_MIN_STD = 8'h10;
	localparam logic [7:0] LUMA_MAX_STD = 8'heb;
	localparam logic [7:0] CHROMA_MAX_STD = 8'hf0;
	localparam logic [7:0] BLACK_LUMA = 8'h10;
	localparam logic [7:0] BLACK_CHROMA = 8'h80;

	// ------------------------------------------------------------
	// embedded codes
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_SAV_ACTIVE = 8'h80;
	localparam logic [7:0] CODE_EAV_ACTIVE = 8'h9d;
	localparam logic [7:0] CODE_SAV_VBLANK = 8'hab;
	localparam logic [7:0] CODE_EAV_VBLANK = 8'hb6;
	localparam logic [7:0] CODE_PREAMBLE_FF = 8'hff;
	localparam logic [7:0] CODE_PREAMBLE_00 = 8'h00;

	// ------------------------------------------------------------
	// output size codes
	// ------------------------------------------------------------
	localparam logic [2:0] SIZE_QVGA = 3'h0;
	localparam logic [2:0] SIZE_VGA = 3'h1;
	localparam logic [2:0] SIZE_CIF = 3'h2;
	localparam logic [2:0] SIZE_QCIF = 3'h3;
	localparam logic [2:0] SIZE_QVGA_ROT = 3'h4;
	localparam logic [2:0] SIZE_CIF_ROT = 3'h5;
	localparam logic [2:0] SIZE_601 = 3'h6;

	// interface style, control bits 5:4
	typedef enum logic [1:0] {
		INTF_CAMERA = 2'h0,
		INTF_SYNC = 2'h1,
		INTF_656 = 2'h2,
		INTF_RSVD = 2'h3
	} intf_t;

	// one 4:2:2 pixel pair from the decoder
	typedef struct packed {
		logic [7:0] cb;
		logic [7:0] y0;
		logic [7:0] cr;
		logic [7:0] y1;
	} pair_t;

	// timing markers from the decoder front end
	typedef struct packed {
		logic locked;
		logic no_signal;
		logic line_start;
		logic active_line;
		logic frame_end;
	} sync_t;

	// the pins toward the host
	typedef struct packed {
		logic [7:0] data;
		logic line_valid;
		logic frame_valid;
		logic pixel_valid;
		logic hsync;
		logic vsync;
	} pins_t;

endpackage

// [hdl/vof_clip.sv]
`timescale 1ns/1ps
`default_nettype none
// clips one pair to the selected output range
module vof_clip
	import vof_pkg::*;
(
	// control
	input wire logic i_range_limit,
	// data
	input wire pair_t i_pair,
	output pair_t o_pair
);

	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	logic [7:0] lo;
	logic [7:0] y_hi;
	logic [7:0] c_hi;

	// full range is also the internal range, so that path is only a guard
	assign lo = i_range_limit ? CODE_MIN_STD : CODE_MIN_FULL;
	assign y_hi = i_range_limit ? LUMA_MAX_STD : CODE_MAX_FULL;
	assign c_hi = i_range_limit ? CHROMA_MAX_STD : CODE_MAX_FULL;
	assign o_pair.cb = clamp(i_pair.cb, lo, c_hi);
	assign o_pair.y0 = clamp(i_pair.y0, lo, y_hi);
	assign o_pair.cr = clamp(i_pair.cr, lo, c_hi);
	assign o_pair.y1 = clamp(i_pair.y1, lo, y_hi);

endmodule
`default_nettype wire

// [hdl/vof_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, vector wide
module vof_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// data
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			meta_q <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule
`default_nettype wire

// [tb/vof_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host receiver: grabs one byte per output clock rise
// ------------------------------------------------------------
module vof_host_model
	import vof_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// pins from the formatter
	input wire logic [7:0] i_data,
	input wire logic i_pclk,
	input wire logic i_pv,
	input wire logic i_fv,
	// what was seen
	output logic [31:0] o_bytes,
	output logic [15:0] o_frames,
	output logic [3:0] o_codes
);
	logic pc_q;
	logic fv_q;
	logic [2:0] n_q;
	logic [23:0] sh_q;

	// short lines or bursts are taken as they come, never flagged
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pc_q <= 1'b0;
			fv_q <= 1'b0;
			n_q <= 3'h0;
			sh_q <= 24'h0;
			o_bytes <= 32'h0;
			o_frames <= 16'h0;
			o_codes <= 4'h0;
		end
		else
		begin
			pc_q <= i_pclk;
			fv_q <= i_fv;
			if (i_fv && !fv_q)
				o_frames <= o_frames + 16'h1;
			if (i_pclk && !pc_q)
			begin
				sh_q <= {sh_q[15:0], i_data};
				if (sh_q == 24'hff0000)
					o_codes <= o_codes | {i_data == CODE_EAV_VBLANK,
						i_data == CODE_SAV_VBLANK, i_data == CODE_EAV_ACTIVE,
						i_data == CODE_SAV_ACTIVE};
				// keep only the first four bytes of each valid burst
				if (i_pv && n_q < 3'h4)
					o_bytes <= {o_bytes[23:0], i_data};
				n_q <= !i_pv ? 3'h0 : (n_q < 3'h4 ? n_q + 3'h1 : n_q);
			end
		end
	end
endmodule
`default_nettype wire

// [tb/vof_formatter_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module vof_formatter_sva
	import vof_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// pins
	input wire logic [7:0] o_data,
	input wire logic o_line_valid_strobe,
	input wire logic o_frame_valid_strobe,
	input wire logic o_pixel_valid_out,
	input wire logic o_pixel_clock_out,
	input wire sync_t i_sync
);
	logic [7:0] ctrl_q;
	logic [7:0] pol_q;
	logic [7:0] mode_q;
	logic [5:0] age_q;
	logic [5:0] ns_q;
	logic calm;
	logic sync_m;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	// shadow registers so the checks know the mode
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			ctrl_q <= 8'h00;
			pol_q <= 8'h00;
			mode_q <= 8'h00;
		end
		else if (i_wr)
		begin
			ctrl_q <= (i_addr == ADDR_OUT_CTRL) ? i_wdata : ctrl_q;
			pol_q <= (i_addr == ADDR_OUT_POL) ? i_wdata : pol_q;
			mode_q <= (i_addr == ADDR_OUT_MODE) ? i_wdata : mode_q;
		end
	end

	// settling counters: the pixel pipe lags a few clocks
	always_ff @(posedge i_ref_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			age_q <= 6'h0;
			ns_q <= 6'h0;
		end
		else
		begin
			age_q <= i_wr ? 6'h0 : (age_q == 6'h3f ? age_q : age_q + 6'h1);
			ns_q <= !i_sync.no_signal ? 6'h0 : (ns_q == 6'h3f ? ns_q : ns_q + 6'h1);
		end
	end
	assign calm = age_q == 6'h3f;
	assign sync_m = calm && ctrl_q[5:4] == INTF_SYNC && pol_q == 8'h00;

	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_RD_CTRL: assert property ($past(i_rd) && $past(i_addr) == ADDR_OUT_CTRL
		|-> o_rdata == $past(ctrl_q)) else $error("control readback wrong");
	AST_RST_OUT: assert property ($fell(i_reset) |-> o_data == 8'h00
		&& !o_frame_valid_strobe && !o_line_valid_strobe && !o_pixel_valid_out)
		else $error("pins not low after reset");
	AST_FULL_RANGE: assert property (sync_m && !ctrl_q[3] && o_pixel_valid_out
		|-> o_data inside {[8'h01:8'hfe]}) else $error("code outside 1..254");
	AST_STD_RANGE: assert property (sync_m && ctrl_q[3] && o_pixel_valid_out
		|-> o_data inside {[8'h10:8'hf0]}) else $error("code outside 16..240");
	AST_BLACK: assert property (sync_m && ns_q == 6'h3f && o_pixel_valid_out
		|-> o_data == BLACK_LUMA || o_data == BLACK_CHROMA) else $error("not black");
	AST_EMBED_QUIET: assert property (calm && ctrl_q[5:4] == INTF_CAMERA
		&& mode_q[1:0] == 2'h1 && pol_q[1:0] == 2'h0
		|-> (!o_line_valid_strobe && !o_frame_valid_strobe) [*3])
		else $error("strobe active in embedded mode");
	AST_BYTE_CLK: assert property (calm && !pol_q[3] && $changed(o_data)
		|-> $rose(o_pixel_clock_out)) else $error("byte changed off clock rise");

	cover property (sync_m && ctrl_q[3] && o_pixel_valid_out);
	cover property (o_data == CODE_EAV_VBLANK);
	cover property ($rose(o_frame_valid_strobe));
endmodule

bind vof_formatter vof_formatter_sva u_vof_formatter_sva (.i_ref_clk, .i_reset,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_data, .o_line_valid_strobe,
	.o_frame_valid_strobe, .o_pixel_valid_out, .o_pixel_clock_out, .i_sync);
`default_nettype wire

// [tb/tb_video_decoder_output_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_video_decoder_output_formatter
	import vof_pkg::*;
;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_pix_clk = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata, o_data, rd_v;
	pair_t i_pair = 32'h00fff505;
	sync_t i_sync = 5'h00;
	logic [9:0] i_pair_count = 10'h005;
	logic o_line_valid_strobe, o_frame_valid_strobe, o_pixel_valid_out;
	logic o_pixel_clock_out, o_horizontal_sync_out, o_vertical_sync_out;
	logic [31:0] m_bytes;
	logic [15:0] m_frames, f0;
	logic [3:0] m_codes;
	logic pc_q = 1'b0, lk = 1'b1, ns = 1'b0, freeze = 1'b0;
	logic [1:0] sub = 2'h0;
	logic [2:0] pos = 3'h0, line = 3'h0;
	logic [20:0] ok_tbl = {7'b1000000, 7'b0001111, 7'b0111101};
	logic [15:0] hs_n = 16'h0000, vs_n = 16'h0000, h0, v0;
	logic hs_q = 1'b0, vs_q = 1'b0;
	int miscompares = 0;
	int n_tests = 0;

	always #10 i_ref_clk = ~i_ref_clk;
	always #80 i_pix_clk = ~i_pix_clk;

	vof_formatter u_vof_formatter (.i_ref_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
		.i_rd, .o_rdata, .i_pix_clk, .i_pair, .i_sync, .i_pair_count, .o_data,
		.o_line_valid_strobe, .o_frame_valid_strobe, .o_pixel_valid_out,
		.o_pixel_clock_out, .o_horizontal_sync_out, .o_vertical_sync_out);
	vof_host_model u_vof_host_model (.i_ref_clk, .i_reset, .i_data(o_data),
		.i_pclk(o_pixel_clock_out), .i_pv(o_pixel_valid_out),
		.i_fv(o_frame_valid_strobe), .o_bytes(m_bytes), .o_frames(m_frames),
		.o_codes(m_codes));

	// decoder stand-in: steps on the pixel fall so inputs hold across its rise
	always @(posedge i_ref_clk)
	begin
		pc_q <= i_pix_clk;
		if (pc_q && !i_pix_clk && !(freeze && line == 3'h2 && pos == 3'h3))
		begin
			sub <= sub + 2'h1;
			if (sub == 2'h3)
				pos <= pos + 3'h1;
			if (sub == 2'h3 && pos == 3'h7)
				line <= (line == 3'h5) ? 3'h0 : line + 3'h1;
		end
		// line start is a one-pixel pulse, or the formatter restarts each pixel
		i_sync <= {lk, ns, pos == 3'h0 && sub == 2'h0, line != 3'h0, line == 3'h5};
	end

	// sync pulse counters, so the sync style pins are looked at
	always @(posedge i_ref_clk)
	begin
		hs_q <= o_horizontal_sync_out;
		vs_q <= o_vertical_sync_out;
		if (o_horizontal_sync_out && !hs_q)
			hs_n <= hs_n + 16'h0001;
		if (o_vertical_sync_out && !vs_q)
			vs_n <= vs_n + 16'h0001;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		rd_v = o_rdata;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wait_pix(input int n);
		repeat (n) @(negedge i_pix_clk);
	endtask

	task test_done;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// a hung handshake must still end the run
	initial
	begin
		#1500000;
		miscompares++;
		test_done();
	end

	initial
	begin
		repeat (10) @(posedge i_ref_clk);
		i_reset <= 1'b0;
		rd(ADDR_OUT_CTRL);
		chk("ctrl_reset", rd_v, RESET_OUT_CTRL);
		rd(ADDR_OUT_POL);
		chk("pol_reset", rd_v, RESET_OUT_POL);
		rd(ADDR_OUT_MODE);
		chk("mode_reset", rd_v, RESET_OUT_MODE);
		wr(8'h05, 8'hff);
		rd(8'h05);
		chk("unmapped", rd_v, 8'h00);
		wr(ADDR_OUT_CTRL, 8'hc5);
		rd(ADDR_OUT_CTRL);
		chk("ctrl_rw", rd_v, 8'hc5);
		for (int st = 0; st < 3; st++)
			for (int sz = 0; sz < 7; sz++)
			begin
				wr(ADDR_OUT_CTRL, {2'h0, st[1:0], 1'b0, sz[2:0]});
				repeat (4) @(posedge i_ref_clk);
				rd(ADDR_STATUS);
				chk("size_ok", rd_v[2], ok_tbl[st * 7 + sz]);
			end
		wr(ADDR_OUT_CTRL, 8'h10);
		wait_pix(400);
		chk("full_range", m_bytes, 32'h01fef505);
		h0 = hs_n;
		v0 = vs_n;
		wait_pix(384);
		chk("hsync_count", hs_n - h0, 16'h000c);
		chk("vsync_count", vs_n - v0, 16'h0002);
		wr(ADDR_OUT_CTRL, 8'h18);
		wait_pix(400);
		chk("std_range", m_bytes, 32'h10ebf010);
		lk <= 1'b0;
		ns <= 1'b1;
		wait_pix(400);
		chk("black", m_bytes, 32'h80108010);
		lk <= 1'b1;
		ns <= 1'b0;
		wr(ADDR_OUT_CTRL, 8'h00);
		wait_pix(200);
		f0 = m_frames;
		wait_pix(576);
		chk("frames", m_frames - f0, 16'h3);
		freeze <= 1'b1;
		wait_pix(400);
		// a stalled decoder lets the line run out, so line valid has ended
		chk("line_valid", o_line_valid_strobe, 1'b0);
		chk("frame_valid", o_frame_valid_strobe, 1'b1);
		wr(ADDR_OUT_POL, 8'h03);
		wait_pix(8);
		chk("line_inv", o_line_valid_strobe, 1'b1);
		chk("frame_inv", o_frame_valid_strobe, 1'b0);
		wr(ADDR_OUT_POL, 8'h00);
		freeze <= 1'b0;
		wr(ADDR_OUT_MODE, 8'h01);
		wait_pix(400);
		chk("codes", m_codes, 4'hf);
		chk("quiet", {o_line_valid_strobe, o_frame_valid_strobe}, 2'h0);
		wr(ADDR_OUT_MODE, 8'h03);
		wait_pix(192);
		f0 = m_frames;
		wait_pix(384);
		chk("strobe_en", m_frames - f0, 16'h2);
		test_done();
	end
endmodule
`default_nettype wire
